// ### hdl/rmmr_edge.sv
// Rising and falling edge detector for the monitor request bit.
// Assumes the request input is already synchronous to MCLK.
`timescale 1ns/1ps
module rmmr_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level in, pulses out
  input  wire logic level,
  output wire logic rise,
  output wire logic fall
);
  import rmmr_pkg::*;
  // ==========================================================
  // Delayed copy
  logic level_r;  // Last cycle's level
  // Keep the previous level for edge compare
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_r <= 1'b0;
    end else begin
      level_r <= level;
    end
  end
  assign rise = level & ~level_r;
  assign fall = ~level & level_r;
endmodule

// ### hdl/rmmr_pkg.sv
// Shared constants for the remote monitor request register block.
// Assumes one clock domain and a status source outside that answers
// item lookups combinationally.
// Functional notes
// - Channel one code plus request loads result one
// - Single station: channel two loads result word one
// - Dual station: channel two lands at word five
// - Dual 32-bit channel one: lower, upper consecutive
// - Dual 32-bit channel two: lower five, upper six
// - Answer zero normally; error code zeroes results
package rmmr_pkg;
  // ==========================================================
  // Widths and reset values
  localparam int          RMMR_WORD_W    = 16;
  localparam int          RMMR_RES_WORDS = 8;
  localparam logic [15:0] RMMR_WORD_RST  = 16'h0000;
  localparam logic [15:0] RMMR_ANS_OK    = 16'h0000;
  // Error code for an unsupported item; value is arbitrary
  localparam logic [15:0] RMMR_ANS_BADCODE = 16'h0001;
  // ==========================================================
  // Result word positions within the output block
  localparam logic [2:0] RMMR_POS_RES1   = 3'h0;
  localparam logic [2:0] RMMR_POS_RES1UP = 3'h1;
  localparam logic [2:0] RMMR_POS_ANSWER = 3'h2;
  localparam logic [2:0] RMMR_POS_RES2LO = 3'h5;
  localparam logic [2:0] RMMR_POS_RES2UP = 3'h6;
  // ==========================================================
  // Request handshake states
  typedef enum logic [1:0] {
    RMMR_IDLE = 2'b00,
    RMMR_LOOK = 2'b01,
    RMMR_DONE = 2'b10
  } rmmr_state_t;
endpackage

// ### hdl/rmmr_top.sv
// Monitor request register bank: takes two monitor item codes and a
// request bit from the master, fetches item values from the status
// source and publishes result words plus an answer code and done bit.
// Assumes the status source answers a code lookup in the same cycle.
`timescale 1ns/1ps
module rmmr_top
  import rmmr_pkg::*;
(
  // Clock and reset
  input  wire logic                   MCLK,
  input  wire logic                   RST,
  // Configuration: high when two stations are occupied
  input  wire logic                   DUAL_STATION,
  // Master input words and request
  input  wire logic [RMMR_WORD_W-1:0] MONITOR_CODE_FIRST,
  input  wire logic [RMMR_WORD_W-1:0] MONITOR_CODE_SECOND,
  input  wire logic                   MONITOR_REQUEST_BIT,
  // Status source lookup, channel one
  output wire logic [RMMR_WORD_W-1:0] LOOK1_CODE,
  input  wire logic [31:0]            LOOK1_VALUE,
  input  wire logic                   LOOK1_VALID,
  // Status source lookup, channel two
  output wire logic [RMMR_WORD_W-1:0] LOOK2_CODE,
  input  wire logic [31:0]            LOOK2_VALUE,
  input  wire logic                   LOOK2_VALID,
  // Output words to the master
  output wire logic [RMMR_WORD_W-1:0] MONITOR_RESULT_FIRST,
  output wire logic [RMMR_WORD_W-1:0] MONITOR_RESULT_SECOND_OR_UPPER,
  output wire logic [RMMR_WORD_W-1:0] ANSWER_RESULT_WORD,
  output wire logic [RMMR_WORD_W-1:0] MONITOR_RESULT_SECOND_LOWER,
  output wire logic [RMMR_WORD_W-1:0] MONITOR_RESULT_SECOND_UPPER,
  output wire logic                   MONITOR_DONE_BIT
);
  // ==========================================================
  // State and storage
  rmmr_state_t      state_r;                      // Handshake state
  rmmr_state_t      state_nxt;                    // Next state
  logic [15:0]      res_r   [RMMR_RES_WORDS];     // Result block
  logic [15:0]      res_nxt [RMMR_RES_WORDS];     // Next result block
  logic             done_r;                       // Done bit
  logic             dual_r;                       // Latched config
  logic [15:0]      code1_r;                      // Captured code one
  logic [15:0]      code2_r;                      // Captured code two
  logic             req_rise;                     // Request rising
  logic             req_fall;                     // Request falling
  logic             load;                         // Publish this cycle
  logic             bad;                          // Some code unknown

  // ==========================================================
  // Request edges
  rmmr_edge u_edge (
    .clk   (MCLK),
    .rst   (RST),
    .level (MONITOR_REQUEST_BIT),
    .rise  (req_rise),
    .fall  (req_fall)
  );

  // ==========================================================
  // Handshake decode
  // Codes are captured on the rising edge so a master changing them
  // mid-lookup cannot tear the answer; lookup happens one cycle later.
  assign LOOK1_CODE = code1_r;
  assign LOOK2_CODE = code2_r;
  assign load       = (state_r == RMMR_LOOK);
  assign bad        = ~LOOK1_VALID | ~LOOK2_VALID;

  // Next-state selection
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RMMR_IDLE: begin
        if (req_rise) begin
          state_nxt = RMMR_LOOK;
        end
      end
      RMMR_LOOK: begin
        state_nxt = RMMR_DONE;
      end
      RMMR_DONE: begin
        if (!MONITOR_REQUEST_BIT) begin
          state_nxt = RMMR_IDLE;
        end
      end
      default: begin
        state_nxt = RMMR_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Result word placement
  // Words not written by the current configuration keep their value;
  // the master is expected to leave unusable positions alone.
  always_comb begin
    for (int i = 0; i < RMMR_RES_WORDS; i++) begin
      res_nxt[i] = res_r[i];
    end
    if (load) begin
      if (bad) begin
        // Unknown item: clear all monitor words, flag error
        res_nxt[RMMR_POS_RES1]   = RMMR_WORD_RST;
        res_nxt[RMMR_POS_RES1UP] = RMMR_WORD_RST;
        res_nxt[RMMR_POS_RES2LO] = RMMR_WORD_RST;
        res_nxt[RMMR_POS_RES2UP] = RMMR_WORD_RST;
        res_nxt[RMMR_POS_ANSWER] = RMMR_ANS_BADCODE;
      end else if (dual_r) begin
        // Lower then upper half per channel
        res_nxt[RMMR_POS_RES1]   = LOOK1_VALUE[15:0];
        res_nxt[RMMR_POS_RES1UP] = LOOK1_VALUE[31:16];
        res_nxt[RMMR_POS_RES2LO] = LOOK2_VALUE[15:0];
        res_nxt[RMMR_POS_RES2UP] = LOOK2_VALUE[31:16];
        res_nxt[RMMR_POS_ANSWER] = RMMR_ANS_OK;
      end else begin
        // Single station: 16-bit values at words zero and one
        res_nxt[RMMR_POS_RES1]   = LOOK1_VALUE[15:0];
        res_nxt[RMMR_POS_RES1UP] = LOOK2_VALUE[15:0];
        res_nxt[RMMR_POS_ANSWER] = RMMR_ANS_OK;
      end
    end
  end

  // ==========================================================
  // State, codes and configuration
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_r <= RMMR_IDLE;
      code1_r <= RMMR_WORD_RST;
      code2_r <= RMMR_WORD_RST;
      dual_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (req_rise && state_r == RMMR_IDLE) begin
        code1_r <= MONITOR_CODE_FIRST;
        code2_r <= MONITOR_CODE_SECOND;
        dual_r  <= DUAL_STATION;
      end
    end
  end

  // Result words and done bit, published together
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < RMMR_RES_WORDS; i++) begin
        res_r[i] <= RMMR_WORD_RST;
      end
      done_r <= 1'b0;
    end else begin
      res_r  <= res_nxt;
      done_r <= (state_nxt == RMMR_DONE);
    end
  end

  // ==========================================================
  // Outputs
  assign MONITOR_RESULT_FIRST           = res_r[RMMR_POS_RES1];
  assign MONITOR_RESULT_SECOND_OR_UPPER = res_r[RMMR_POS_RES1UP];
  assign ANSWER_RESULT_WORD             = res_r[RMMR_POS_ANSWER];
  assign MONITOR_RESULT_SECOND_LOWER    = res_r[RMMR_POS_RES2LO];
  assign MONITOR_RESULT_SECOND_UPPER    = res_r[RMMR_POS_RES2UP];
  assign MONITOR_DONE_BIT               = done_r;

  // ==========================================================
  // Checks
  chk_done_follows_req: assert property (
    @(posedge MCLK) disable iff (RST)
    (req_rise && state_r == RMMR_IDLE) |-> ##2 MONITOR_DONE_BIT)
    else $error("done not raised two cycles after request");

  chk_done_drops: assert property (
    @(posedge MCLK) disable iff (RST)
    (MONITOR_DONE_BIT && !MONITOR_REQUEST_BIT) |=> !MONITOR_DONE_BIT)
    else $error("done held after request dropped");

  chk_result_one: assert property (
    @(posedge MCLK) disable iff (RST)
    (load && !bad) |=> MONITOR_RESULT_FIRST == $past(LOOK1_VALUE[15:0]))
    else $error("result one not loaded");

  chk_single_second: assert property (
    @(posedge MCLK) disable iff (RST)
    (load && !bad && !dual_r) |=>
      MONITOR_RESULT_SECOND_OR_UPPER == $past(LOOK2_VALUE[15:0]))
    else $error("single station word two wrong");

  chk_dual_upper1: assert property (
    @(posedge MCLK) disable iff (RST)
    (load && !bad && dual_r) |=>
      MONITOR_RESULT_SECOND_OR_UPPER == $past(LOOK1_VALUE[31:16]))
    else $error("channel one upper half wrong");

  chk_dual_lower2: assert property (
    @(posedge MCLK) disable iff (RST)
    (load && !bad && dual_r) |=>
      MONITOR_RESULT_SECOND_LOWER == $past(LOOK2_VALUE[15:0]))
    else $error("channel two lower word wrong");

  chk_dual_upper2: assert property (
    @(posedge MCLK) disable iff (RST)
    (load && !bad && dual_r) |=>
      MONITOR_RESULT_SECOND_UPPER == $past(LOOK2_VALUE[31:16]))
    else $error("channel two upper word wrong");

  chk_bad_zeroes: assert property (
    @(posedge MCLK) disable iff (RST)
    (load && bad) |=> (ANSWER_RESULT_WORD == RMMR_ANS_BADCODE
      && MONITOR_RESULT_FIRST == RMMR_WORD_RST
      && MONITOR_RESULT_SECOND_OR_UPPER == RMMR_WORD_RST
      && MONITOR_RESULT_SECOND_LOWER == RMMR_WORD_RST
      && MONITOR_RESULT_SECOND_UPPER == RMMR_WORD_RST))
    else $error("error answer did not clear results");

  // Falling request while done is up must clear done on the next edge
  chk_fall_clears: assert property (
    @(posedge MCLK) disable iff (RST)
    (req_fall && MONITOR_DONE_BIT) |=> !MONITOR_DONE_BIT)
    else $error("done held after request fell");

  chk_done_waits: assert property (
    @(posedge MCLK) disable iff (RST)
    (MONITOR_DONE_BIT && MONITOR_REQUEST_BIT) |=> MONITOR_DONE_BIT)
    else $error("done dropped while request still high");

  chk_answer_ok: assert property (
    @(posedge MCLK) disable iff (RST)
    (load && !bad) |=> ANSWER_RESULT_WORD == RMMR_ANS_OK)
    else $error("answer not zero after good lookup");

  // Single station leaves words five and six to their previous owner
  chk_single_keeps: assert property (
    @(posedge MCLK) disable iff (RST)
    (load && !bad && !dual_r) |=>
      ($stable(MONITOR_RESULT_SECOND_LOWER)
      && $stable(MONITOR_RESULT_SECOND_UPPER)))
    else $error("single station touched words five and six");
endmodule

// ### verification/rmmr_status_model.sv
// Status source model: answers one channel's item lookup at once.
// Assumes codes below 16'h0100 are supported items, all others are not.
`timescale 1ns/1ps
module rmmr_status_model
  import rmmr_pkg::*;
(
  // Lookup code from the block
  input  wire logic [RMMR_WORD_W-1:0] code,
  // Item value and support flag
  output wire logic [31:0]            value,
  output wire logic                   valid
);
  // ============================================================
  // Lookup
  // Halves differ so that a swapped half shows up at once
  assign value = {code ^ 16'h5A5A, ~code};
  // Unsupported items still drive a value, so zeroing is visible
  assign valid = (code < 16'h0100);
endmodule

// ### verification/rmmr_top_tb.sv
// Testbench for the monitor request register bank.
// Assumes the status model answers lookups combinationally.
`timescale 1ns/1ps
module rmmr_top_tb;
  import rmmr_pkg::*;
  // ============================================================
  // Signals
  logic        MCLK = 1'b0;
  logic        RST, DUAL_STATION, MONITOR_REQUEST_BIT;
  logic [15:0] MONITOR_CODE_FIRST, MONITOR_CODE_SECOND, LOOK1_CODE;
  logic [15:0] LOOK2_CODE, W0, W1, ANS, W5, W6;
  logic [31:0] LOOK1_VALUE, LOOK2_VALUE;
  logic        LOOK1_VALID, LOOK2_VALID, MONITOR_DONE_BIT;
  int          mismatches = 0;
  int          samples_checked = 0;
  // ============================================================
  // Clock, design and status source
  initial forever #12.5 MCLK = ~MCLK;
  rmmr_top dut (.MCLK(MCLK), .RST(RST), .DUAL_STATION(DUAL_STATION),
    .MONITOR_CODE_FIRST(MONITOR_CODE_FIRST),
    .MONITOR_CODE_SECOND(MONITOR_CODE_SECOND),
    .MONITOR_REQUEST_BIT(MONITOR_REQUEST_BIT), .LOOK1_CODE(LOOK1_CODE),
    .LOOK1_VALUE(LOOK1_VALUE), .LOOK1_VALID(LOOK1_VALID),
    .LOOK2_CODE(LOOK2_CODE), .LOOK2_VALUE(LOOK2_VALUE),
    .LOOK2_VALID(LOOK2_VALID), .MONITOR_RESULT_FIRST(W0),
    .MONITOR_RESULT_SECOND_OR_UPPER(W1), .ANSWER_RESULT_WORD(ANS),
    .MONITOR_RESULT_SECOND_LOWER(W5), .MONITOR_RESULT_SECOND_UPPER(W6),
    .MONITOR_DONE_BIT(MONITOR_DONE_BIT));
  rmmr_status_model src1 (.code(LOOK1_CODE), .value(LOOK1_VALUE),
    .valid(LOOK1_VALID));
  rmmr_status_model src2 (.code(LOOK2_CODE), .value(LOOK2_VALUE),
    .valid(LOOK2_VALID));
  // ============================================================
  // Helpers
  // Expected item value, worked out independently of the model
  function automatic logic [31:0] item(input logic [15:0] c);
    item = {c ^ 16'h5A5A, ~c};
  endfunction
  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic words(input logic [15:0] e0, e1, ea, e5, e6);
    check("word0", W0, e0);
    check("word1", W1, e1);
    check("answer", ANS, ea);
    check("word5", W5, e5);
    check("word6", W6, e6);
  endtask
  // Waits at falling edges for done to reach a level, bounded
  task automatic wait_done(input logic lvl);
    int n;
    n = 0;
    @(negedge MCLK);
    while (MONITOR_DONE_BIT !== lvl) begin
      n++;
      if (n > 8) begin
        mismatches++;
        complete_run();
      end
      @(negedge MCLK);
    end
  endtask
  // One whole handshake: rise, done, hold, drop, done low
  task automatic request(input logic dual, input logic [15:0] c1, c2);
    @(posedge MCLK);
    DUAL_STATION <= dual;
    MONITOR_CODE_FIRST <= c1;
    MONITOR_CODE_SECOND <= c2;
    MONITOR_REQUEST_BIT <= 1'b1;
    wait_done(1'b1);
    repeat (3) @(negedge MCLK);
    check("done held", MONITOR_DONE_BIT, 1'b1);
    @(posedge MCLK);
    MONITOR_REQUEST_BIT <= 1'b0;
    wait_done(1'b0);
    @(negedge MCLK);
  endtask
  // ============================================================
  // Main sequence
  initial begin
    logic [31:0] a, b, d;
    RST = 1'b1;
    DUAL_STATION = 1'b0;
    MONITOR_REQUEST_BIT = 1'b0;
    MONITOR_CODE_FIRST = 16'h0000;
    MONITOR_CODE_SECOND = 16'h0000;
    repeat (6) @(posedge MCLK);
    RST <= 1'b0;
    @(negedge MCLK);
    words(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    // Single station: words 5 and 6 stay at reset value
    a = item(16'h0012);
    b = item(16'h0034);
    request(1'b0, 16'h0012, 16'h0034);
    words(a[15:0], b[15:0], RMMR_ANS_OK, 16'h0000, 16'h0000);
    // Dual station with an unsupported second code
    request(1'b1, 16'h0012, 16'h0100);
    words(16'h0000, 16'h0000, RMMR_ANS_BADCODE, 16'h0000, 16'h0000);
    // Dual station 32-bit on both channels, answer back to zero
    a = item(16'h0056);
    b = item(16'h0078);
    request(1'b1, 16'h0056, 16'h0078);
    words(a[15:0], a[31:16], RMMR_ANS_OK, b[15:0], b[31:16]);
    check("answer ok", ANS, RMMR_ANS_OK);
    // Single station again: words 5 and 6 keep the dual values
    a = item(16'h0009);
    b = item(16'h00FF);
    d = item(16'h0078);
    request(1'b0, 16'h0009, 16'h00FF);
    words(a[15:0], b[15:0], RMMR_ANS_OK, d[15:0], d[31:16]);
    check("word5 kept", W5, {16'h0000, d[15:0]});
    // Single station with an unsupported first code
    request(1'b0, 16'hFFFF, 16'h0034);
    check("answer", ANS, RMMR_ANS_BADCODE);
    check("word0", W0, 16'h0000);
    check("word1", W1, 16'h0000);
    check("word5", W5, 16'h0000);
    check("word6", W6, 16'h0000);
    complete_run();
  end
endmodule
